// file: include/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Pad numbering inside the block
  // ----------------------------------------------------------------
  localparam int PAD_COUNT = 12;              // Port 2 pins 4..7, port 3 pins 0..7
  localparam int P2_PADS   = 4;               // Upper nibble of port 2
  localparam int P3_PADS   = 8;               // Whole of port 3
  localparam int PAD_P2_4  = 0;               // Timer / analog channel 4 pad
  localparam int PAD_P2_5  = 1;               // External resistor pad
  localparam int PAD_P2_6  = 2;               // Crystal input pad
  localparam int PAD_P2_7  = 3;               // Crystal output pad
  localparam int PAD_P3_0  = 4;               // Serial A clock / B slave enable
  localparam int PAD_P3_1  = 5;               // Serial B data out / i2c data
  localparam int PAD_P3_2  = 6;               // Serial B data in / i2c clock
  localparam int PAD_P3_3  = 7;               // Serial B clock / A slave enable
  localparam int PAD_P3_4  = 8;               // Serial A transmit
  localparam int PAD_P3_5  = 9;               // Serial A receive
  localparam int PAD_P3_6  = 10;              // Analog channel 6
  localparam int PAD_P3_7  = 11;              // Analog channel 7

  // ----------------------------------------------------------------
  // Field positions in the write data
  // ----------------------------------------------------------------
  localparam int P2_FIELD_LSB  = 4;           // Port 2 pins 4..7 sit in bits 7:4
  localparam int AE_FIELD_LSB  = 4;           // Analog enable bits 7:4 are kept
  localparam int OSC_FIELD_BIT = 0;           // Resistor select in bit 0
  localparam int AE_CH4 = 0;                  // Stored index of enable bit 4
  localparam int AE_CH5 = 1;                  // Stored index of enable bit 5
  localparam int AE_CH6 = 2;                  // Stored index of enable bit 6
  localparam int AE_CH7 = 3;                  // Stored index of enable bit 7

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] P2_DIR_RST = 4'h0;   // All inputs
  localparam logic [3:0] P2_SEL_RST = 4'hC;   // Crystal pins start in oscillator use
  localparam logic [7:0] P3_DIR_RST = 8'h00;  // All inputs
  localparam logic [7:0] P3_SEL_RST = 8'h00;  // All general I/O
  localparam logic [3:0] AE_RST     = 4'h0;   // No analog pins
  localparam logic       OSC_RST    = 1'b0;   // Resistor not connected

endpackage

// file: core/pad_stage.sv
`timescale 1ns/1ps
module pad_stage
(
  input  wire logic core_clk,      // Core clock
  input  wire logic rst_n,         // Async reset, active low
  input  wire logic nxtOut,        // Next output level
  input  wire logic nxtOe,         // Next output enable
  input  wire logic nxtSchmitt,    // Next input buffer enable
  input  wire logic padIn,         // Level seen at the pad
  output logic      padOut,        // Registered output level
  output logic      padOe,         // Registered output enable
  output logic      schmittEn,     // Registered input buffer enable
  output logic      padInReg       // Registered, gated input level
);

  // ----------------------------------------------------------------
  // Output stage and input capture of one pad
  // ----------------------------------------------------------------
  logic padOut_ff;                 // Output level
  logic padOe_ff;                  // Output enable
  logic schmitt_ff;                // Input buffer enable
  logic padIn_ff;                  // Captured input
  logic nxtPadIn;                  // Gated input level

  // Disabled input buffer reads low, so no floating analog level leaks in
  always_comb
  begin
    nxtPadIn = schmitt_ff & padIn;
  end

  // Register everything so the pad sees glitch-free controls
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padOut_ff  <= 1'b0;
      padOe_ff   <= 1'b0;
      schmitt_ff <= 1'b1;
      padIn_ff   <= 1'b0;
    end
    else
    begin
      padOut_ff  <= nxtOut;
      padOe_ff   <= nxtOe;
      schmitt_ff <= nxtSchmitt;
      padIn_ff   <= nxtPadIn;
    end
  end

  assign padOut    = padOut_ff;
  assign padOe     = padOe_ff;
  assign schmittEn = schmitt_ff;
  assign padInReg  = padIn_ff;

endmodule

// file: core/port2_port3_pin_function_mux.sv
`timescale 1ns/1ps
module port2_port3_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                    core_clk,          // Core clock, 125 MHz
  input  wire logic                    rst_n,             // Async reset, active low
  input  wire logic [7:0]              writeData,         // Shared software write data
  input  wire logic                    p2DirWrite,        // Write port2_direction_bits
  input  wire logic                    p2SelWrite,        // Write port2_function_select_bits
  input  wire logic                    p3DirWrite,        // Write port3_direction_bits
  input  wire logic                    p3SelWrite,        // Write port3_function_select_bits
  input  wire logic                    aeWrite,           // Write analog_input_enable_bits
  input  wire logic                    oscWrite,          // Write oscillator_resistor_select
  input  wire logic [P2_PADS-1:0]      port2OutBits,      // GPIO output levels, port 2 pins 4..7
  input  wire logic [P3_PADS-1:0]      port3OutBits,      // GPIO output levels, port 3
  input  wire logic                    timerAChannel2Out, // timer_a_channel2_output
  input  wire logic                    crystalDrive,      // Oscillator driver level for crystal_out
  input  wire logic [5:0]              serialOut,         // Serial levels for port 3 pins 0..5
  input  wire logic [5:0]              serialOe,          // Serial drive requests, pins 0..5
  input  wire logic                    serialAClockUsed,  // serial_a_clock needed on pin 3.0
  input  wire logic                    serialBClockUsed,  // serial_b_clock needed on pin 3.3
  input  wire logic [PAD_COUNT-1:0]    padIn,             // Pad levels
  output logic      [PAD_COUNT-1:0]    padOut,            // Pad output levels
  output logic      [PAD_COUNT-1:0]    padOe,             // Pad output enables, high drives
  output logic      [PAD_COUNT-1:0]    schmittEn,         // Pad input buffer enables
  output logic      [P2_PADS-1:0]      port2InBits,       // Input read, port 2 pins 4..7
  output logic      [P3_PADS-1:0]      port3InBits,       // Input read and serial inputs, port 3
  output logic      [3:0]              analogConnect,     // Channels 4..7 tied to pads
  output logic                         roscConnect,       // External DCO resistor tied to pad
  output logic                         crystalInSel,      // crystal_in routed to pad
  output logic                         crystalOutSel,     // crystal_out routed to pad
  output logic                         serialBForce3Wire, // serial_interface_b forced 3-wire
  output logic                         serialAForce3Wire  // serial_interface_a forced 3-wire
);
  import pin_mux_pkg::*;

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic [P2_PADS-1:0] port2_direction_bits_ff;        // port2_direction_bits, pins 4..7
  logic [P2_PADS-1:0] port2_function_select_bits_ff;        // port2_function_select_bits, pins 4..7
  logic [P3_PADS-1:0] port3_direction_bits_ff;        // port3_direction_bits
  logic [P3_PADS-1:0] port3_function_select_bits_ff;        // port3_function_select_bits
  logic [3:0]         ae_ff;           // analog_input_enable_bits 7:4
  logic               osc_ff;          // oscillator_resistor_select
  logic [P2_PADS-1:0] nxt_port2_direction_bits;       // Next direction, port 2
  logic [P2_PADS-1:0] nxt_port2_function_select_bits;       // Next select, port 2
  logic [P3_PADS-1:0] nxt_port3_direction_bits;       // Next direction, port 3
  logic [P3_PADS-1:0] nxt_port3_function_select_bits;       // Next select, port 3
  logic [3:0]         nxt_ae;          // Next analog enables
  logic               nxt_osc;         // Next resistor select

  // Software writes; untouched registers hold
  always_comb
  begin
    nxt_port2_direction_bits = port2_direction_bits_ff;
    nxt_port2_function_select_bits = port2_function_select_bits_ff;
    nxt_port3_direction_bits = port3_direction_bits_ff;
    nxt_port3_function_select_bits = port3_function_select_bits_ff;
    nxt_ae    = ae_ff;
    nxt_osc   = osc_ff;
    if (p2DirWrite)
      nxt_port2_direction_bits = writeData[P2_FIELD_LSB +: P2_PADS];
    if (p2SelWrite)
      nxt_port2_function_select_bits = writeData[P2_FIELD_LSB +: P2_PADS];
    if (p3DirWrite)
      nxt_port3_direction_bits = writeData;
    if (p3SelWrite)
      nxt_port3_function_select_bits = writeData;
    if (aeWrite)
      nxt_ae = writeData[AE_FIELD_LSB +: 4];
    if (oscWrite)
      nxt_osc = writeData[OSC_FIELD_BIT];
  end

  // Both reset kinds arrive on rst_n; crystal pins wake in oscillator use
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port2_direction_bits_ff <= P2_DIR_RST;
      port2_function_select_bits_ff <= P2_SEL_RST;
      port3_direction_bits_ff <= P3_DIR_RST;
      port3_function_select_bits_ff <= P3_SEL_RST;
      ae_ff    <= AE_RST;
      osc_ff   <= OSC_RST;
    end
    else
    begin
      port2_direction_bits_ff <= nxt_port2_direction_bits;
      port2_function_select_bits_ff <= nxt_port2_function_select_bits;
      port3_direction_bits_ff <= nxt_port3_direction_bits;
      port3_function_select_bits_ff <= nxt_port3_function_select_bits;
      ae_ff    <= nxt_ae;
      osc_ff   <= nxt_osc;
    end
  end

  // ----------------------------------------------------------------
  // Function selection per pad
  // ----------------------------------------------------------------
  logic [PAD_COUNT-1:0] padDir;        // Direction bits in pad order
  logic [PAD_COUNT-1:0] padSel;        // Select bits in pad order
  logic [PAD_COUNT-1:0] padGpio;       // GPIO levels in pad order
  logic [PAD_COUNT-1:0] padAnalog;     // Analog enables in pad order
  logic [PAD_COUNT-1:0] nxtOut;        // Next pad levels
  logic [PAD_COUNT-1:0] nxtOe;         // Next pad enables
  logic [PAD_COUNT-1:0] nxtSchmitt;    // Next input buffer enables

  assign padDir  = {port3_direction_bits_ff, port2_direction_bits_ff};
  assign padSel  = {port3_function_select_bits_ff, port2_function_select_bits_ff};
  assign padGpio = {port3OutBits, port2OutBits};

  // Only four pads have an analog role; the rest never see one
  always_comb
  begin
    padAnalog           = '0;
    padAnalog[PAD_P2_4] = ae_ff[AE_CH4];
    padAnalog[PAD_P3_0] = ae_ff[AE_CH5];
    padAnalog[PAD_P3_6] = ae_ff[AE_CH6];
    padAnalog[PAD_P3_7] = ae_ff[AE_CH7];
  end

  // GPIO first, then special functions, analog last so it always wins
  always_comb
  begin
    for (int i = 0; i < PAD_COUNT; i++)
    begin
      nxtOut[i]     = padGpio[i];
      nxtOe[i]      = padDir[i];
      nxtSchmitt[i] = 1'b1;
    end
    // Timer output only with direction 1; select with direction 0 stays GPIO
    if (padSel[PAD_P2_4] && padDir[PAD_P2_4])
    begin
      nxtOut[PAD_P2_4] = timerAChannel2Out;
      nxtOe[PAD_P2_4]  = 1'b1;
    end
    // Resistor select overrides everything on this pad
    if (osc_ff)
    begin
      nxtOut[PAD_P2_5]     = 1'b0;
      nxtOe[PAD_P2_5]      = 1'b0;
      nxtSchmitt[PAD_P2_5] = 1'b0;
    end
    else if (padSel[PAD_P2_5])
    begin
      nxtOut[PAD_P2_5] = 1'b0;
      nxtOe[PAD_P2_5]  = padDir[PAD_P2_5];  // Ground only with direction 1
    end
    // Crystal pads ignore direction while selected
    if (padSel[PAD_P2_6])
    begin
      nxtOut[PAD_P2_6]     = 1'b0;
      nxtOe[PAD_P2_6]      = 1'b0;
      nxtSchmitt[PAD_P2_6] = 1'b0;
    end
    // Driver stays on until select clears; input use then fights it
    if (padSel[PAD_P2_7])
    begin
      nxtOut[PAD_P2_7] = crystalDrive;
      nxtOe[PAD_P2_7]  = 1'b1;
    end
    // Serial pads: the serial module owns the direction
    for (int j = 0; j < 6; j++)
    begin
      if (padSel[PAD_P3_0 + j])
      begin
        nxtOut[PAD_P3_0 + j] = serialOut[j];
        nxtOe[PAD_P3_0 + j]  = serialOe[j];
      end
    end
    // Analog disables driver and trigger to stop cross currents
    for (int k = 0; k < PAD_COUNT; k++)
    begin
      if (padAnalog[k])
      begin
        nxtOut[k]     = 1'b0;
        nxtOe[k]      = 1'b0;
        nxtSchmitt[k] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad stages
  // ----------------------------------------------------------------
  logic [PAD_COUNT-1:0] padInReg;      // Gated, registered pad inputs

  genvar g;
  generate
    for (g = 0; g < PAD_COUNT; g++)
    begin : gPad
      pad_stage uStage
      (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .nxtOut     (nxtOut[g]),
        .nxtOe      (nxtOe[g]),
        .nxtSchmitt (nxtSchmitt[g]),
        .padIn      (padIn[g]),
        .padOut     (padOut[g]),
        .padOe      (padOe[g]),
        .schmittEn  (schmittEn[g]),
        .padInReg   (padInReg[g])
      );
    end
  endgenerate

  assign port2InBits = padInReg[P2_PADS-1:0];
  assign port3InBits = padInReg[PAD_COUNT-1:P2_PADS];

  // ----------------------------------------------------------------
  // Routing status toward the analog, clock and serial blocks
  // ----------------------------------------------------------------
  logic [3:0] analog_ff;               // Channel connections
  logic       rosc_ff;                 // Resistor connection
  logic       xin_ff;                  // Crystal input routed
  logic       crystal_out_ff;                 // Crystal output routed
  logic       forceB_ff;               // B forced to 3-wire
  logic       forceA_ff;               // A forced to 3-wire
  logic [3:0] nxt_analog;              // Next channel connections
  logic       nxt_rosc;                // Next resistor connection
  logic       nxt_xin;                 // Next crystal input routing
  logic       nxt_crystal_out;                // Next crystal output routing
  logic       nxt_forceB;              // Next B fallback
  logic       nxt_forceA;              // Next A fallback

  // Clock functions take the shared pad from the slave enables
  always_comb
  begin
    nxt_analog = ae_ff;
    nxt_rosc   = osc_ff;
    nxt_xin    = padSel[PAD_P2_6];
    nxt_crystal_out   = padSel[PAD_P2_7];
    nxt_forceB = padSel[PAD_P3_0] & ~ae_ff[AE_CH5] & serialAClockUsed;
    nxt_forceA = padSel[PAD_P3_3] & serialBClockUsed;
  end

  // Status flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_ff <= AE_RST;
      rosc_ff   <= OSC_RST;
      xin_ff    <= P2_SEL_RST[PAD_P2_6];
      crystal_out_ff   <= P2_SEL_RST[PAD_P2_7];
      forceB_ff <= 1'b0;
      forceA_ff <= 1'b0;
    end
    else
    begin
      analog_ff <= nxt_analog;
      rosc_ff   <= nxt_rosc;
      xin_ff    <= nxt_xin;
      crystal_out_ff   <= nxt_crystal_out;
      forceB_ff <= nxt_forceB;
      forceA_ff <= nxt_forceA;
    end
  end

  assign analogConnect     = analog_ff;
  assign roscConnect       = rosc_ff;
  assign crystalInSel      = xin_ff;
  assign crystalOutSel     = crystal_out_ff;
  assign serialBForce3Wire = forceB_ff;
  assign serialAForce3Wire = forceA_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gpio_dir_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!port3_function_select_bits_ff[6] && !ae_ff[AE_CH6]) |=> (padOe[PAD_P3_6] == $past(port3_direction_bits_ff[6])))
    else $error("gpio enable does not follow direction");

  a_reset_defaults: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (port3_function_select_bits_ff == 8'h00 && port2_function_select_bits_ff[1:0] == 2'h0 && port2_function_select_bits_ff[3:2] == 2'h3))
    else $error("select bits wrong after reset");

  a_xin_routed: assert property (@(posedge core_clk) disable iff (!rst_n)
    port2_function_select_bits_ff[2] |=> (crystalInSel && !padOe[PAD_P2_6] && !schmittEn[PAD_P2_6]))
    else $error("crystal input not routed");

  a_crystal_out_driven: assert property (@(posedge core_clk) disable iff (!rst_n)
    port2_function_select_bits_ff[3] |=> (padOe[PAD_P2_7] && padOut[PAD_P2_7] == $past(crystalDrive)))
    else $error("crystal output not driven");

  a_timer_output: assert property (@(posedge core_clk) disable iff (!rst_n)
    port2_function_select_bits_ff[0] && port2_direction_bits_ff[0] && !ae_ff[AE_CH4] |=> (padOe[PAD_P2_4] && padOut[PAD_P2_4] == $past(timerAChannel2Out)))
    else $error("timer output not on pad");

  a_analog_isolate: assert property (@(posedge core_clk) disable iff (!rst_n)
    ae_ff[AE_CH7] |=> (!padOe[PAD_P3_7] && !schmittEn[PAD_P3_7]) ##1 !port3InBits[7])
    else $error("analog pad not isolated");

  a_analog_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (analogConnect == $past(ae_ff)))
    else $error("analog channel map wrong");

  a_rosc_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    osc_ff |=> (roscConnect && !padOe[PAD_P2_5]))
    else $error("resistor pad not released");

  a_serial_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    port3_function_select_bits_ff[4] |=> (padOe[PAD_P3_4] == $past(serialOe[4]) && padOut[PAD_P3_4] == $past(serialOut[4])))
    else $error("serial pad not owned by serial module");

  a_clock_prio: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (serialAForce3Wire == $past(port3_function_select_bits_ff[3] && serialBClockUsed)
         && serialBForce3Wire == $past(port3_function_select_bits_ff[0] && !ae_ff[AE_CH5] && serialAClockUsed)))
    else $error("clock did not take the shared pad");

endmodule

// file: testbench/port2_port3_pin_function_mux_tb.sv
`timescale 1ns/1ps
module port2_port3_pin_function_mux_tb;
  import pin_mux_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              core_clk  = 1'b0;   // 125 MHz core clock
  logic              rst_n     = 1'b0;   // Reset, active low
  logic [7:0]        writeData = 8'h00;  // Shared write data
  logic [5:0]        wrStb     = 6'h00;  // port2_direction_bits,port2_function_select_bits,port3_direction_bits,port3_function_select_bits,ae,osc
  logic [3:0]        p2Out     = 4'h0;   // GPIO levels, port 2
  logic [7:0]        p3Out     = 8'h00;  // GPIO levels, port 3
  logic              timerOut  = 1'b0;   // Timer channel level
  logic              xDrive    = 1'b1;   // Oscillator driver level
  logic [5:0]        serOut    = 6'h00;  // Serial levels
  logic [5:0]        serOe     = 6'h00;  // Serial drive requests
  logic              aClk      = 1'b0;   // Serial A clock needed
  logic              bClk      = 1'b0;   // Serial B clock needed
  logic [11:0]       padIn     = 12'h000; // Pad levels
  logic [11:0]       padOut, padOe, schmittEn; // Pad controls
  logic [3:0]        p2In, anaConn;      // Port 2 read, analog links
  logic [7:0]        p3In;               // Port 3 read
  logic              rosc, xinSel, xoutSel, bForce, aForce; // Status levels
  int                fails     = 0;      // Mismatch count
  int                nChecks   = 0;      // Comparison count

  // Free-running clock, 8 ns period
  always #4 core_clk = ~core_clk;

  port2_port3_pin_function_mux dut_u
  (
    .core_clk(core_clk), .rst_n(rst_n), .writeData(writeData),
    .p2DirWrite(wrStb[0]), .p2SelWrite(wrStb[1]), .p3DirWrite(wrStb[2]),
    .p3SelWrite(wrStb[3]), .aeWrite(wrStb[4]), .oscWrite(wrStb[5]),
    .port2OutBits(p2Out), .port3OutBits(p3Out), .timerAChannel2Out(timerOut),
    .crystalDrive(xDrive), .serialOut(serOut), .serialOe(serOe),
    .serialAClockUsed(aClk), .serialBClockUsed(bClk), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .schmittEn(schmittEn), .port2InBits(p2In),
    .port3InBits(p3In), .analogConnect(anaConn), .roscConnect(rosc),
    .crystalInSel(xinSel), .crystalOutSel(xoutSel),
    .serialBForce3Wire(bForce), .serialAForce3Wire(aForce)
  );

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  // Case inequality so an unknown never passes
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Let n edges pass, then look after their updates landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One strobe pulse; pads follow one edge after the control bit
  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge core_clk);
    wrStb[idx] <= 1'b1;
    writeData  <= d;
    @(posedge core_clk);
    wrStb      <= 6'h00;
    tick(1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Crystal pins start in oscillator use, the rest as GPIO inputs
  task automatic t_reset;
    chk(padOe, 12'h008, "reset enables");
    chk(12'(padOut[3]), 12'h001, "crystal drive");
    chk(schmittEn & 12'hFF7, 12'hFF3, "reset buffers");
    chk({5'h00, xinSel, xoutSel, rosc, anaConn}, 12'h060, "reset status");
    wr(0, 8'hF0);
    // Direction must not move the crystal pins
    chk(12'(padOe[3:0]), 12'h00B, "crystal with dir");
    @(posedge core_clk);
    xDrive <= 1'b0;
    tick(1);
    chk(12'({padOe[3], padOut[3]}), 12'h002, "crystal follows drive");
    $display("test reset done");
  endtask

  // Plain GPIO both ways, crystal pins released by software
  task automatic t_gpio;
    wr(1, 8'h00);
    wr(2, 8'hFF);
    @(posedge core_clk);
    p2Out <= 4'hA;
    p3Out <= 8'h5A;
    tick(1);
    chk(padOe, 12'hFFF, "gpio enables");
    chk(padOut, 12'h5AA, "gpio levels");
    chk(12'({xinSel, xoutSel}), 12'h000, "crystal off");
    wr(0, 8'h00);
    wr(2, 8'h00);
    @(posedge core_clk);
    padIn <= 12'hA5C;
    tick(2);
    chk(padOe, 12'h000, "gpio inputs");
    chk({p3In, p2In}, 12'hA5C, "gpio read");
    $display("test gpio done");
  endtask

  // Timer only with select and direction both set
  task automatic t_timer;
    wr(1, 8'h10);
    wr(0, 8'h10);
    @(posedge core_clk);
    timerOut <= 1'b1;
    p2Out    <= 4'h0;
    tick(1);
    chk(12'({padOe[0], padOut[0]}), 12'h003, "timer out");
    wr(0, 8'h00);
    chk(12'(padOe[0]), 12'h000, "select without dir");
    $display("test timer done");
  endtask

  // Each enable bit alone, all pads set to output
  task automatic t_analog;
    int          aPad [4];
    logic [11:0] rd;
    aPad = '{PAD_P2_4, PAD_P3_0, PAD_P3_6, PAD_P3_7};
    wr(1, 8'h00);
    wr(0, 8'hF0);
    wr(2, 8'hFF);
    @(posedge core_clk);
    padIn <= 12'hFFF;
    for (int i = 0; i < 4; i++)
    begin
      wr(4, 8'(8'h10 << i));
      tick(1);
      rd = {p3In, p2In};
      chk(12'(anaConn), 12'(4'h1 << i), "analog map");
      chk(12'({padOe[aPad[i]], schmittEn[aPad[i]], rd[aPad[i]]}), 12'h000, "analog pad");
    end
    wr(4, 8'h00);
    $display("test analog done");
  endtask

  // Resistor select beats select and direction
  task automatic t_rosc;
    wr(1, 8'h20);
    wr(0, 8'h20);
    @(posedge core_clk);
    p2Out <= 4'h2;
    tick(1);
    chk(12'({padOe[1], padOut[1]}), 12'h002, "ground drive");
    wr(5, 8'h01);
    chk(12'({rosc, padOe[1]}), 12'h002, "resistor");
    wr(5, 8'h00);
    wr(1, 8'h00);
    $display("test rosc done");
  endtask

  // Serial module owns direction; clocks force the other 3-wire
  task automatic t_serial;
    wr(2, 8'h00);
    wr(3, 8'h3F);
    @(posedge core_clk);
    serOut <= 6'h2A;
    serOe  <= 6'h15;
    tick(1);
    chk(12'(padOut[9:4]), 12'h02A, "serial levels");
    chk(12'(padOe[9:4]), 12'h015, "serial enables");
    @(posedge core_clk);
    serOe <= 6'h2A;
    aClk  <= 1'b1;
    bClk  <= 1'b1;
    tick(1);
    chk(12'(padOe[9:4]), 12'h02A, "serial owns dir");
    chk(12'({bForce, aForce}), 12'h003, "forced 3-wire");
    wr(3, 8'h00);
    chk(12'({bForce, aForce, padOe[9:4]}), 12'h000, "serial off");
    $display("test serial done");
  endtask

  // A second reset in mid-run brings back the crystal defaults
  task automatic t_rereset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    chk(padOe, 12'h008, "re-reset enables");
    chk({5'h00, xinSel, xoutSel, rosc, anaConn}, 12'h060, "re-reset status");
    $display("test rereset done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_gpio();
    t_timer();
    t_analog();
    t_rosc();
    t_serial();
    t_rereset();
    report_and_stop();
  end

  // Whole run is about 110 cycles; 4000 means a hang
  initial
  begin
    repeat (4000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end
endmodule
